// ---- dv/eeprog_prog_model.sv ----
// Purpose: programmer model for the parallel programming bus
// Assumes: device timing as in the port hand-over
// Notes:   bus floats high through pull-ups when nobody drives
`timescale 1ns/1ps
module eeprog_prog_model (
    input  wire logic                     sys_clk,
    input  wire eeprog_pkg::eeprog_byte_t bus,
    output logic                          latch,
    output logic                          sel_n,
    output logic                          rd_n,
    output logic                          wr_n,
    output eeprog_pkg::eeprog_byte_t      drv,
    output logic                          drv_en
);
    import eeprog_pkg::*;
    initial begin
        {latch, drv_en, drv} = '0;
        {sel_n, rd_n, wr_n} = 3'b111;
    end
    // opens with a latch pulse, then one strobe
    task automatic acc(input eeprog_byte_t a, d, input logic wr, cs_n,
                       output eeprog_byte_t q);
        @(posedge sys_clk);
        latch <= 1'b1;
        drv <= a;
        drv_en <= 1'b1;
        @(posedge sys_clk);
        latch <= 1'b0;
        @(posedge sys_clk);
        sel_n <= cs_n;
        drv <= d;
        drv_en <= wr;
        if (wr) wr_n <= 1'b0; else rd_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 q = bus;
        @(posedge sys_clk);
        {sel_n, rd_n, wr_n} <= 3'b111; // select raised between accesses
        drv_en <= 1'b0;
    endtask : acc
endmodule : eeprog_prog_model

// ---- dv/tb_top.sv ----
// Purpose: self-checking bench of the programming port
// Assumes: one clock of 4 ns; pull-ups on the shared bus
// Notes:   expected bytes come from a shadow array
`timescale 1ns/1ps
module tb_top;
    import eeprog_pkg::*;
    logic         sys_clk = 0, srst = 1, prog_if_reset = 0;
    logic [2:0]   ms = 3'b010;
    logic         latch, sel_n, rd_n, wr_n, drv_en, oe, pmode, wr, cs;
    eeprog_byte_t drv, dout, bus, q, a, d;
    eeprog_byte_t shadow [256];
    logic [31:0]  lf = 32'h10bf;
    int           fail_count = 0, compares = 0;
    assign bus = oe ? dout : (drv_en ? drv : 8'hFF);
    initial forever #2 sys_clk = ~sys_clk; // clock never stops
    eeprog_prog_model pm (.sys_clk(sys_clk), .bus(bus), .latch(latch), .sel_n(sel_n),
        .rd_n(rd_n), .wr_n(wr_n), .drv(drv), .drv_en(drv_en));
    eeprog_port dut (.sys_clk(sys_clk), .srst(srst), .prog_if_reset(prog_if_reset),
        .mode_select_0(ms[0]), .mode_select_1(ms[1]), .mode_select_2(ms[2]),
        .prog_addr_latch(latch), .prog_select_n(sel_n), .prog_read_strobe_n(rd_n),
        .prog_write_strobe_n(wr_n), .prog_addr_data_bus_in(bus),
        .prog_addr_data_bus_out(dout), .prog_addr_data_bus_oe(oe), .prog_mode(pmode));
    function automatic eeprog_byte_t nxt();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf[7:0];
    endfunction : nxt
    task automatic chk(string n, eeprog_byte_t e, eeprog_byte_t g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d errors %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    task automatic xfer(eeprog_byte_t ad, dd, logic w, c);
        pm.acc(ad, dd, w, c, q);
        if (w && !c && ms == 3'b010) shadow[ad] = dd;
        if (!w) chk("read", c ? 8'hFF : shadow[ad], q);
    endtask : xfer
    always @(negedge sys_clk) begin
        if (!srst) begin
            chk("oe", {7'h0, !prog_if_reset && ms == 3'b010 && !latch && !sel_n && !rd_n},
                {7'h0, oe});
            chk("mode", {7'h0, ms == 3'b010}, {7'h0, pmode});
        end
    end
    initial begin
        foreach (shadow[i]) shadow[i] = 8'h00;
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        for (int i = 0; i < 6; i++) xfer(nxt(), 8'h00, 1'b0, 1'b0);
        xfer(8'hFF, 8'hA5, 1'b1, 1'b0);
        xfer(8'hFF, 8'h00, 1'b0, 1'b0);
        for (int i = 0; i < 50; i++) begin
            a = nxt();
            d = nxt();
            wr = nxt() > 8'h70;
            cs = nxt() < 8'h30;
            xfer(a, d, wr, cs);
        end
        for (int k = 0; k < 8; k++) begin
            @(posedge sys_clk) ms <= 3'(k);
            xfer(8'hFF, nxt(), 1'b1, 1'b0);
        end
        @(posedge sys_clk) ms <= 3'b010;
        xfer(8'hFF, 8'h00, 1'b0, 1'b0);
        @(posedge sys_clk) prog_if_reset <= 1'b1;
        @(posedge sys_clk) prog_if_reset <= 1'b0;
        foreach (shadow[i]) shadow[i] = 8'h00;
        xfer(8'hFF, 8'h00, 1'b0, 1'b0);
        xfer(a, 8'h00, 1'b0, 1'b0);
        summarize();
    end
    initial begin
        #20000;
        fail_count++;
        summarize();
    end
endmodule : tb_top

// ---- src/eeprog_map.svh ----
// Purpose: constants of the programming port
// Assumes: one 250 MHz clock, synchronous inputs
// Notes:   register file depth and reset values are local choices
`ifndef EEPROG_MAP_SVH
`define EEPROG_MAP_SVH
`define EEPROG_DATA_W      8
`define EEPROG_ADDR_W      8
`define EEPROG_DEPTH       256
`define EEPROG_RST_DATA    8'h00
`define EEPROG_RST_ADDR    8'h00
`define EEPROG_MS0_LEVEL   1'b0
`define EEPROG_MS1_LEVEL   1'b1
`define EEPROG_MS2_LEVEL   1'b0
`endif

// ---- src/eeprog_pkg.sv ----
// Purpose: types of the programming port
// Assumes: eeprog_map.svh supplies widths
// Notes:   none
`include "eeprog_map.svh"
package eeprog_pkg;
    typedef logic [`EEPROG_DATA_W-1:0] eeprog_byte_t;
    typedef logic [`EEPROG_ADDR_W-1:0] eeprog_addr_t;
    typedef enum logic [1:0] {EEPROG_IDLE, EEPROG_READ, EEPROG_WRITE} eeprog_acc_t;
endpackage : eeprog_pkg

// ---- src/eeprog_port.sv ----
// Purpose: parallel programming-mode register port
// Assumes: all pins synchronous to sys_clk; clock runs throughout
// Notes:   read data is a registered copy of the addressed register
`timescale 1ns/1ps
`include "eeprog_map.svh"
module eeprog_port (
    input  wire logic                     sys_clk,
    input  wire logic                     srst,
    input  wire logic                     prog_if_reset,
    input  wire logic                     mode_select_0,
    input  wire logic                     mode_select_1,
    input  wire logic                     mode_select_2,
    input  wire logic                     prog_addr_latch,
    input  wire logic                     prog_select_n,
    input  wire logic                     prog_read_strobe_n,
    input  wire logic                     prog_write_strobe_n,
    input  wire eeprog_pkg::eeprog_byte_t prog_addr_data_bus_in,
    output eeprog_pkg::eeprog_byte_t      prog_addr_data_bus_out,
    output logic                          prog_addr_data_bus_oe,
    output logic                          prog_mode
);
    import eeprog_pkg::*;

    // ------------------------------------------------------------
    // mode and reset
    // ------------------------------------------------------------
    logic         clr;
    logic         ale_r;
    eeprog_addr_t addr_r;
    eeprog_acc_t  acc_r;
    eeprog_acc_t  acc_nxt;
    logic         wr_en;
    eeprog_byte_t rd_data;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // a strobe counts only with select low; shared so logic and checks agree
    function automatic logic strobe_on(
        input logic sel_n,
        input logic strobe_n
    );
        return !sel_n && !strobe_n;
    endfunction : strobe_on

    // each mode pin is held against its own required level
    function automatic logic mode_ok(
        input logic ms0,
        input logic ms1,
        input logic ms2
    );
        return (ms0 == `EEPROG_MS0_LEVEL)
            && (ms1 == `EEPROG_MS1_LEVEL)
            && (ms2 == `EEPROG_MS2_LEVEL);
    endfunction : mode_ok

    // mode pins are static straps in practice; decode is combinational
    assign prog_mode = mode_ok(mode_select_0, mode_select_1, mode_select_2);
    assign clr = srst || prog_if_reset;

    // ------------------------------------------------------------
    // address latch
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            ale_r <= 1'b0;
        end else begin
            ale_r <= prog_addr_latch;
        end
    end

    // trailing edge: bus still holds the address in the sample before
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            addr_r <= `EEPROG_RST_ADDR;
        end else if (prog_mode && prog_addr_latch) begin
            addr_r <= prog_addr_data_bus_in; // last value before fall is kept
        end
    end

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    always_comb begin
        acc_nxt = EEPROG_IDLE;
        if (prog_mode && !prog_addr_latch) begin
            if (strobe_on(prog_select_n, prog_read_strobe_n)) begin
                acc_nxt = EEPROG_READ;
            end else if (strobe_on(prog_select_n, prog_write_strobe_n)) begin
                acc_nxt = EEPROG_WRITE;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clr) begin
            acc_r <= EEPROG_IDLE;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // ------------------------------------------------------------
    // write path
    // ------------------------------------------------------------

    // one store per write strobe, on its first low cycle
    assign wr_en = (acc_nxt == EEPROG_WRITE) && (acc_r != EEPROG_WRITE);

    eeprog_regmem u_mem (
        .sys_clk (sys_clk),
        .clr     (clr),
        .wr_en   (wr_en),
        .addr    (addr_r),
        .wr_data (prog_addr_data_bus_in),
        .rd_data (rd_data)
    );

    // ------------------------------------------------------------
    // bus drive
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            prog_addr_data_bus_out <= `EEPROG_RST_DATA;
        end else begin
            prog_addr_data_bus_out <= rd_data;
        end
    end

    // enable follows the strobes directly so the bus frees at once
    assign prog_addr_data_bus_oe = !clr && (acc_nxt == EEPROG_READ);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // pins are taken as the device samples them; no setup slack is modelled
    sequence s_latch_fall;
        prog_mode && prog_addr_latch ##1 !prog_addr_latch;
    endsequence

    sequence s_write_edge;
        wr_en;
    endsequence

    // registered read path: the stored byte reaches the pins two edges later
    sequence s_readback_due;
        1'b1 ##2 prog_addr_data_bus_out == $past(prog_addr_data_bus_in, 2);
    endsequence

    sequence s_read_release;
        !prog_read_strobe_n ##1 prog_read_strobe_n;
    endsequence

    a_addr_capture: assert property (@(posedge sys_clk) disable iff (clr)
        s_latch_fall |-> addr_r == $past(prog_addr_data_bus_in))
        else $error("address not taken at latch fall");

    a_addr_fall: assert property (@(posedge sys_clk) disable iff (clr)
        prog_mode && $past(prog_mode) && ale_r && !prog_addr_latch
        |-> addr_r == $past(prog_addr_data_bus_in))
        else $error("address not kept after latch fall");

    a_oe_read_only: assert property (@(posedge sys_clk)
        prog_addr_data_bus_oe |-> strobe_on(prog_select_n, prog_read_strobe_n))
        else $error("bus driven outside a read");

    a_oe_on_read: assert property (@(posedge sys_clk) disable iff (clr)
        (mode_ok(mode_select_0, mode_select_1, mode_select_2)
         && strobe_on(prog_select_n, prog_read_strobe_n) && !prog_addr_latch)
        |-> prog_addr_data_bus_oe)
        else $error("read not driven");

    a_oe_released: assert property (@(posedge sys_clk)
        s_read_release |-> !prog_addr_data_bus_oe)
        else $error("bus still driven after read");

    a_oe_in_reset: assert property (@(posedge sys_clk)
        clr |-> !prog_addr_data_bus_oe)
        else $error("bus driven during reset");

    a_select_gates: assert property (@(posedge sys_clk)
        prog_select_n |-> !wr_en && !prog_addr_data_bus_oe)
        else $error("strobe acted without select");

    a_read_priority: assert property (@(posedge sys_clk)
        strobe_on(prog_select_n, prog_read_strobe_n) |-> !wr_en)
        else $error("write taken during a read");

    a_latch_blocks: assert property (@(posedge sys_clk)
        prog_addr_latch |-> !wr_en && !prog_addr_data_bus_oe)
        else $error("strobe acted while address latch open");

    a_write_store: assert property (@(posedge sys_clk) disable iff (clr)
        s_write_edge |-> s_readback_due)
        else $error("written value not read back");

    a_write_once: assert property (@(posedge sys_clk) disable iff (clr)
        s_write_edge |=> !wr_en)
        else $error("held write strobe stored twice");

    a_reset_clear: assert property (@(posedge sys_clk)
        prog_if_reset |=> addr_r == `EEPROG_RST_ADDR && acc_r == EEPROG_IDLE
                         && prog_addr_data_bus_out == `EEPROG_RST_DATA)
        else $error("reset left state");

    a_mode_gates: assert property (@(posedge sys_clk)
        !mode_ok(mode_select_0, mode_select_1, mode_select_2)
        |-> !wr_en && !prog_addr_data_bus_oe)
        else $error("access outside programming mode");

    a_addr_hold: assert property (@(posedge sys_clk) disable iff (clr)
        !$past(clr) && !ale_r |-> $stable(addr_r))
        else $error("address moved without latch");
endmodule : eeprog_port

// ---- src/eeprog_regmem.sv ----
// Purpose: register array of the programming port, registered read
// Assumes: single clock, synchronous clear
// Notes:   clear walks nothing; array is cleared in one cycle
`timescale 1ns/1ps
`include "eeprog_map.svh"
module eeprog_regmem (
    input  wire logic                   sys_clk,
    input  wire logic                   clr,
    input  wire logic                   wr_en,
    input  wire eeprog_pkg::eeprog_addr_t addr,
    input  wire eeprog_pkg::eeprog_byte_t wr_data,
    output eeprog_pkg::eeprog_byte_t      rd_data
);
    import eeprog_pkg::*;
    eeprog_byte_t mem_r [`EEPROG_DEPTH];

    always_ff @(posedge sys_clk) begin
        if (clr) begin
            for (int i = 0; i < `EEPROG_DEPTH; i++) begin
                mem_r[i] <= `EEPROG_RST_DATA;
            end
        end else if (wr_en) begin
            mem_r[addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clr) begin
            rd_data <= `EEPROG_RST_DATA;
        end else if (wr_en) begin
            rd_data <= wr_data;
        end else begin
            rd_data <= mem_r[addr];
        end
    end
endmodule : eeprog_regmem
